/* design/hcsp_pkg.sv */
// Package for the host command/status port: map, status bits, states
package hcsp_pkg;
  // Register offsets within the port's address window
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_DATA = 2'h1;
  // Status bit positions
  localparam int BIT_CMD_INVALID = 0;
  localparam int BIT_RESERVED = 1;
  localparam int BIT_DATA_IN_READY = 2;
  localparam int BIT_CMD_BUSY = 3;
  localparam int BIT_ADAPTER_READY = 4;
  localparam int BIT_INIT_REQUIRED = 5;
  localparam int BIT_DIAG_FAILURE = 6;
  localparam int BIT_DIAG_ACTIVE = 7;
  // Command codes
  localparam logic [7:0] CMD_MAILBOX_INIT = 8'h01;
  localparam logic [7:0] CMD_START_SCSI = 8'h02;
  localparam logic [7:0] CMD_ENABLE_SLOT_IRQ = 8'h05;
  // Self-test duration
  localparam int DIAG_TIME_US = 20;
  localparam int CLK_MHZ = 250;
  localparam int DIAG_CYCLES = DIAG_TIME_US * CLK_MHZ;
  localparam int DATA_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Byte travelling from the host into the local processor
  typedef struct packed {
    logic first;
    logic [7:0] value;
  } hcsp_cmd_byte_type;

  // Port engine states
  typedef enum logic [1:0] {
    HCSP_DIAG = 2'b00,
    HCSP_IDLE = 2'b01,
    HCSP_FAILED = 2'b10
  } hcsp_state_type;
endpackage : hcsp_pkg

/* design/hcsp_fifo.sv */
// Reply byte FIFO with valid/ready on both sides
`timescale 1ns/100ps
module hcsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage array, no reset needed
  always_ff @(posedge clk)
  begin
    if (clk_en && push)
      mem[wr_reg] <= in_data;
  end

  // Pointers and count; flush drops anything queued
  always_ff @(posedge clk)
  begin
    if (reset || (clk_en && flush))
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end
    else if (clk_en)
    begin
      if (push)
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : hcsp_fifo

/* design/hcsp_sync.sv */
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
module hcsp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage is read only by the second
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else if (clk_en)
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : hcsp_sync

/* design/hcsp_port.sv */
// Host command/status port: status, command/parameter and data-in regs
// Function
// (R1) Loading a reply byte into data-in sets data-in-ready.
// (R2) Host read of data-in clears data-in-ready at once.
// (R3) Host waits for data-in-ready before each further reply byte.
// (R4) After the last reply byte is taken, raise command-complete.
// (R5) Invalid command or parameter byte sets command-invalid.
// (R6) Every command ends with command-complete; invalid ones also flag.
// (R7) Host reads command-invalid only while command-complete is set.
// (R8) Status bit one always reads zero.
// (R9) Host write of command/parameter byte sets busy.
// (R10) Busy clears once the local processor took the byte.
// (R11) Host checks busy clear before each command byte.
// (R12) Adapter-ready flag shows a new command may be accepted.
// (R13) Host issues commands only when ready, except codes 02 and 05.
// (R14) Wrong byte count may stop acceptance; flagged as command-invalid.
// (R15) Successful diagnostics set init-required; failure does not.
// (R16) Mailbox-init command success clears init-required.
// (R17) Self-test error sets diagnostic-failure; only hard reset clears.
// (R18) Diagnostic-active set during self-test, cleared on success.
// (R19) Command-complete held back while interrupt-valid or data ready.
// (R20) Hard reset aborts commands, flushes, reruns diagnostics.
// (R21) Status reads have no side effects.
`timescale 1ns/100ps
module hcsp_port #(
  parameter int DIAG_CYCLES = hcsp_pkg::DIAG_CYCLES,
  parameter int FIFO_DEPTH = hcsp_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Host I/O strobes, already in clk domain as one-cycle pulses
  input wire logic [1:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // Control register hard reset bit, pulse
  input wire logic hard_reset_request,
  // Interrupt register interrupt-valid bit (asynchronous)
  input wire logic interrupt_valid,
  // Self-test outcome from on-board logic (asynchronous level)
  input wire logic diag_error,
  // Local processor side: command bytes out
  output hcsp_pkg::hcsp_cmd_byte_type mpu_cmd,
  output logic mpu_cmd_valid,
  input wire logic mpu_cmd_taken,
  input wire logic mpu_cmd_bad,
  input wire logic mpu_cmd_done,
  input wire logic mpu_cmd_ok,
  input wire logic mpu_busy,
  // Local processor side: reply bytes in
  input wire logic [7:0] mpu_reply,
  input wire logic mpu_reply_valid,
  input wire logic mpu_reply_last,
  output logic mpu_reply_ready,
  // Pulse to set command-complete in the interrupt register
  output logic command_complete,
  output logic [7:0] adapter_status
);
  localparam int CW = $clog2(DIAG_CYCLES + 1);
  localparam logic [CW-1:0] DIAG_LAST = CW'(DIAG_CYCLES - 1);

  hcsp_pkg::hcsp_state_type state_reg;
  logic [CW-1:0] diag_cnt_reg;
  logic cmd_invalid_reg;
  logic data_in_ready_reg;
  logic cmd_busy_reg;
  logic init_required_reg;
  logic diag_failure_reg;
  logic diag_active_reg;
  logic stalled_reg;
  logic [7:0] data_in_reg;
  logic last_loaded_reg;
  logic cc_pending_reg;
  logic expect_first_reg;
  logic mailbox_init_reg;
  logic interrupt_valid_sync;
  logic diag_err_sync;
  logic [8:0] fifo_out;
  logic fifo_out_valid;
  logic fifo_in_ready;
  logic fifo_pop;
  logic data_rd;
  logic cmd_wr;
  logic hard_rst;
  logic [7:0] status_next;

  assign data_rd = host_rd && (host_addr == hcsp_pkg::ADDR_DATA);
  assign cmd_wr = host_wr && (host_addr == hcsp_pkg::ADDR_DATA);
  assign hard_rst = hard_reset_request;

  // Asynchronous levels enter through two flops
  hcsp_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in({interrupt_valid, diag_error}),
    .sync_out({interrupt_valid_sync, diag_err_sync})
  );

  // Reply bytes queue here; ready back-pressures the local processor
  hcsp_fifo #(.WIDTH(hcsp_pkg::DATA_WIDTH + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .flush(hard_rst), // [R20]
    .in_data({mpu_reply_last, mpu_reply}),
    .in_valid(mpu_reply_valid && mpu_reply_ready), // Same ready as shown
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );

  // Next byte moves in only once the host has taken the previous one
  assign fifo_pop = fifo_out_valid && (!data_in_ready_reg || data_rd);

  // Diagnostic sequencer after reset or programmed hard reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= hcsp_pkg::HCSP_DIAG;
      diag_cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      if (hard_rst) // [R20]
      begin
        state_reg <= hcsp_pkg::HCSP_DIAG;
        diag_cnt_reg <= '0;
      end
      else
      begin
        case (state_reg)
          hcsp_pkg::HCSP_DIAG:
          begin
            if (diag_err_sync)
              state_reg <= hcsp_pkg::HCSP_FAILED;
            else if (diag_cnt_reg == DIAG_LAST)
              state_reg <= hcsp_pkg::HCSP_IDLE;
            else
              diag_cnt_reg <= diag_cnt_reg + 1'b1;
          end
          hcsp_pkg::HCSP_IDLE: state_reg <= hcsp_pkg::HCSP_IDLE;
          hcsp_pkg::HCSP_FAILED: state_reg <= hcsp_pkg::HCSP_FAILED;
          default: state_reg <= hcsp_pkg::HCSP_DIAG;
        endcase
      end
    end
  end

  // Diagnostic flags; failure is cleared only by a hard reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      diag_active_reg <= 1'b1;
      diag_failure_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (hard_rst)
      begin
        diag_active_reg <= 1'b1; // [R18]
        diag_failure_reg <= 1'b0; // [R17]
      end
      else if (state_reg == hcsp_pkg::HCSP_DIAG)
      begin
        if (diag_err_sync)
          diag_failure_reg <= 1'b1; // [R17]
        else if (diag_cnt_reg == DIAG_LAST)
          diag_active_reg <= 1'b0; // [R18]
      end
    end
  end

  // Init-required: set on pass, cleared by good mailbox init
  always_ff @(posedge clk)
  begin
    if (reset)
      init_required_reg <= 1'b0;
    else if (clk_en)
    begin
      if (hard_rst)
        init_required_reg <= 1'b0;
      else if (state_reg == hcsp_pkg::HCSP_DIAG && !diag_err_sync
               && diag_cnt_reg == DIAG_LAST)
        init_required_reg <= 1'b1; // [R15]
      else if (mpu_cmd_done && mpu_cmd_ok && mailbox_init_reg)
        init_required_reg <= 1'b0; // [R16]
    end
  end

  // Track command opcode so mailbox init completion is recognised
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      expect_first_reg <= 1'b1;
      mailbox_init_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (hard_rst || mpu_cmd_done
          || (data_rd && data_in_ready_reg && last_loaded_reg))
        expect_first_reg <= 1'b1;
      else if (cmd_wr && !cmd_busy_reg)
        expect_first_reg <= 1'b0;
      if (hard_rst)
        mailbox_init_reg <= 1'b0;
      else if (cmd_wr && !cmd_busy_reg && expect_first_reg)
        mailbox_init_reg <= (host_wdata == hcsp_pkg::CMD_MAILBOX_INIT);
    end
  end

  // Command byte latch towards the local processor
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mpu_cmd <= '0;
      mpu_cmd_valid <= 1'b0;
      cmd_busy_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (hard_rst) // [R20]
      begin
        mpu_cmd_valid <= 1'b0;
        cmd_busy_reg <= 1'b0;
      end
      else if (cmd_wr && !cmd_busy_reg && !stalled_reg
               && state_reg == hcsp_pkg::HCSP_IDLE)
      begin
        mpu_cmd <= '{first: expect_first_reg, value: host_wdata};
        mpu_cmd_valid <= 1'b1;
        cmd_busy_reg <= 1'b1; // [R9]
      end
      else if (mpu_cmd_taken)
      begin
        // Byte read and processed, host may write again
        mpu_cmd_valid <= 1'b0;
        cmd_busy_reg <= 1'b0; // [R10]
      end
    end
  end

  // Command-invalid; a set wins over the clear at a new command
  always_ff @(posedge clk)
  begin
    if (reset)
      cmd_invalid_reg <= 1'b0;
    else if (clk_en)
    begin
      if (mpu_cmd_bad)
        cmd_invalid_reg <= 1'b1; // [R5] [R14]
      else if (hard_rst)
        cmd_invalid_reg <= 1'b0;
      else if (cmd_wr && !cmd_busy_reg && expect_first_reg)
        cmd_invalid_reg <= 1'b0;
    end
  end

  // Sequence error stops acceptance until a hard reset
  always_ff @(posedge clk)
  begin
    if (reset)
      stalled_reg <= 1'b0;
    else if (clk_en)
    begin
      if (hard_rst)
        stalled_reg <= 1'b0;
      else if (cmd_wr && cmd_busy_reg)
        stalled_reg <= 1'b1; // [R14]
    end
  end

  // Data-in register and its ready flag; load beats the clear
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      data_in_reg <= hcsp_pkg::ZERO_BYTE;
      data_in_ready_reg <= 1'b0;
      last_loaded_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (hard_rst)
      begin
        data_in_ready_reg <= 1'b0;
        last_loaded_reg <= 1'b0;
      end
      else if (fifo_pop)
      begin
        data_in_reg <= fifo_out[7:0];
        last_loaded_reg <= fifo_out[8];
        data_in_ready_reg <= 1'b1; // [R1]
      end
      else if (data_rd)
        data_in_ready_reg <= 1'b0; // [R2] [R3]
    end
  end

  // Pending completion: reply end or command end, released when clear
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cc_pending_reg <= 1'b0;
      command_complete <= 1'b0;
    end
    else if (clk_en)
    begin
      command_complete <= 1'b0;
      if (hard_rst)
        cc_pending_reg <= 1'b0;
      else if (cc_pending_reg && !interrupt_valid_sync && !data_in_ready_reg
               && !fifo_out_valid)
      begin
        cc_pending_reg <= mpu_cmd_done; // A new end is kept, not lost
        command_complete <= 1'b1; // [R19]
      end
      else if ((data_rd && data_in_ready_reg && last_loaded_reg)
               || mpu_cmd_done)
        cc_pending_reg <= 1'b1; // [R4] [R6]
    end
  end

  // Status byte; reading it never changes a flag
  always_comb
  begin
    status_next = hcsp_pkg::ZERO_BYTE;
    status_next[hcsp_pkg::BIT_CMD_INVALID] = cmd_invalid_reg; // [R7]
    status_next[hcsp_pkg::BIT_RESERVED] = 1'b0; // [R8]
    status_next[hcsp_pkg::BIT_DATA_IN_READY] = data_in_ready_reg;
    status_next[hcsp_pkg::BIT_CMD_BUSY] = cmd_busy_reg;
    status_next[hcsp_pkg::BIT_ADAPTER_READY] =
      (state_reg == hcsp_pkg::HCSP_IDLE) && !mpu_busy
      && !stalled_reg && !cc_pending_reg; // [R12] [R13]
    status_next[hcsp_pkg::BIT_INIT_REQUIRED] = init_required_reg;
    status_next[hcsp_pkg::BIT_DIAG_FAILURE] = diag_failure_reg;
    status_next[hcsp_pkg::BIT_DIAG_ACTIVE] = diag_active_reg;
  end

  // Registered outputs; host read data is the addressed register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      adapter_status <= hcsp_pkg::ZERO_BYTE;
      host_rdata <= hcsp_pkg::ZERO_BYTE;
      mpu_reply_ready <= 1'b0;
    end
    else if (clk_en)
    begin
      adapter_status <= status_next; // [R21]
      mpu_reply_ready <= fifo_in_ready;
      if (host_addr == hcsp_pkg::ADDR_DATA)
        host_rdata <= data_in_reg;
      else if (host_addr == hcsp_pkg::ADDR_STATUS)
        host_rdata <= status_next;
      else
        host_rdata <= hcsp_pkg::ZERO_BYTE;
    end
  end
endmodule : hcsp_port

/* tb/hcsp_port_chk.sv */
// Concurrent checks on the host command/status port pins
`timescale 1ns/100ps
module hcsp_port_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [1:0] host_addr,
  input wire logic host_wr,
  input wire logic hard_reset_request,
  input wire logic interrupt_valid,
  input wire logic mpu_cmd_valid,
  input wire logic mpu_cmd_taken,
  input wire logic command_complete,
  input wire logic [7:0] adapter_status
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Bits: 1 spare, 2 data, 3 busy, 4 ready, 5 init, 6 fail, 7 test
  a_reserved_zero: assert property (!adapter_status[1])
    else $error("reserved status bit set");
  a_write_busy: assert property (
    clk_en && host_wr && host_addr == 2'h1 && adapter_status[4] &&
    !adapter_status[3] && !mpu_cmd_valid |=> mpu_cmd_valid ##[0:1]
    adapter_status[3]) else $error("accepted write left busy clear");
  a_taken_frees: assert property (
    mpu_cmd_taken && !host_wr |-> ##[1:3] !adapter_status[3])
    else $error("busy stayed set after byte taken");
  // Two cycles of slack cover the pulse and the status lag
  a_fail_sticky: assert property (
    adapter_status[6] && !hard_reset_request &&
    !$past(hard_reset_request) && !$past(hard_reset_request, 2)
    |=> adapter_status[6]) else $error("failure flag cleared alone");
  a_fail_no_init: assert property (
    adapter_status[6] |-> !adapter_status[5])
    else $error("init required set with failed test");
  a_test_not_ready: assert property (
    adapter_status[7] |-> !adapter_status[4])
    else $error("ready shown during self-test");
  a_cc_no_data: assert property (
    command_complete |-> !adapter_status[2])
    else $error("completion while reply byte waits");
  a_cc_held_interrupt_valid: assert property (
    interrupt_valid [*4] ##3 1'b1 |-> !command_complete)
    else $error("completion while interrupt pending");
endmodule : hcsp_port_chk

/* tb/hcsp_mpu_model.sv */
// Local processor model: consumes command bytes, returns reply bytes
`timescale 1ns/100ps
module hcsp_mpu_model #(
  parameter int REPLY_LEN = 10
) (
  input wire logic clk,
  input wire logic reset,
  input wire hcsp_pkg::hcsp_cmd_byte_type mpu_cmd,
  input wire logic mpu_cmd_valid,
  output logic mpu_cmd_taken,
  output logic mpu_cmd_bad,
  output logic mpu_cmd_done,
  output logic mpu_cmd_ok,
  output logic [7:0] mpu_reply,
  output logic mpu_reply_valid,
  output logic mpu_reply_last,
  input wire logic mpu_reply_ready
);
  logic [7:0] opcode;
  int left;
  // Pushes every other cycle, as the ready flag runs one cycle late
  task automatic send_reply;
    for (int i = 0; i < REPLY_LEN; i++)
    begin
      mpu_reply <= 8'ha0 + 8'(i);
      mpu_reply_last <= (i == REPLY_LEN - 1);
      mpu_reply_valid <= 1'b1;
      do
        @(posedge clk);
      while (mpu_reply_ready !== 1'b1);
      mpu_reply_valid <= 1'b0;
      mpu_reply <= ~mpu_reply;
      @(posedge clk);
    end
  endtask : send_reply
  // Slow consumer so the host really sees busy; 01 takes four more bytes
  initial
  begin
    {mpu_cmd_taken, mpu_cmd_bad, mpu_cmd_done, mpu_cmd_ok} = 4'h0;
    {mpu_reply, mpu_reply_valid, mpu_reply_last} = 10'h000;
    opcode = 8'h00;
    left = 0;
    forever
    begin
      @(posedge clk);
      if (!reset && mpu_cmd_valid === 1'b1)
      begin
        repeat (2) @(posedge clk);
        if (mpu_cmd.first)
          opcode = mpu_cmd.value;
        left = mpu_cmd.first ? (opcode == 8'h01 ? 4 : 0) : left - 1;
        mpu_cmd_bad <= !(opcode inside {8'h01, 8'h04});
        mpu_cmd_taken <= 1'b1;
        @(posedge clk);
        {mpu_cmd_taken, mpu_cmd_bad} <= 2'h0;
        if (left == 0 && opcode == 8'h04)
          send_reply();
        else if (left == 0)
        begin
          mpu_cmd_done <= 1'b1;
          mpu_cmd_ok <= (opcode == 8'h01);
          @(posedge clk);
          {mpu_cmd_done, mpu_cmd_ok} <= 2'h0;
        end
      end
    end
  end
endmodule : hcsp_mpu_model

/* tb/hcsp_port_tb_top.sv */
// Testbench top for the host command/status port
`timescale 1ns/100ps
module hcsp_port_tb_top;
  logic clk, reset, clk_en, host_rd, host_wr, hard_reset_request;
  logic interrupt_valid, diag_error, mpu_cmd_valid, mpu_cmd_taken;
  logic mpu_cmd_bad, mpu_cmd_done, mpu_cmd_ok, mpu_busy, mpu_reply_valid;
  logic mpu_reply_last, mpu_reply_ready, command_complete;
  logic [1:0] host_addr;
  logic [7:0] host_wdata, host_rdata, mpu_reply, adapter_status, rd;
  hcsp_pkg::hcsp_cmd_byte_type mpu_cmd;
  int err_count, n_compared, cc_count;
  hcsp_port #(.DIAG_CYCLES(16), .FIFO_DEPTH(8)) i_dut (.clk(clk),
    .reset(reset), .clk_en(clk_en), .host_addr(host_addr),
    .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .hard_reset_request(hard_reset_request),
    .interrupt_valid(interrupt_valid), .diag_error(diag_error),
    .mpu_cmd(mpu_cmd), .mpu_cmd_valid(mpu_cmd_valid),
    .mpu_cmd_taken(mpu_cmd_taken), .mpu_cmd_bad(mpu_cmd_bad),
    .mpu_cmd_done(mpu_cmd_done), .mpu_cmd_ok(mpu_cmd_ok),
    .mpu_busy(mpu_busy), .mpu_reply(mpu_reply),
    .mpu_reply_valid(mpu_reply_valid), .mpu_reply_last(mpu_reply_last),
    .mpu_reply_ready(mpu_reply_ready),
    .command_complete(command_complete), .adapter_status(adapter_status));
  hcsp_mpu_model #(.REPLY_LEN(10)) i_mpu (.clk(clk), .reset(reset),
    .mpu_cmd(mpu_cmd), .mpu_cmd_valid(mpu_cmd_valid),
    .mpu_cmd_taken(mpu_cmd_taken), .mpu_cmd_bad(mpu_cmd_bad),
    .mpu_cmd_done(mpu_cmd_done), .mpu_cmd_ok(mpu_cmd_ok),
    .mpu_reply(mpu_reply), .mpu_reply_valid(mpu_reply_valid),
    .mpu_reply_last(mpu_reply_last), .mpu_reply_ready(mpu_reply_ready));
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Completion pulses counted for the expected totals
  always @(posedge clk)
    if (command_complete === 1'b1)
      cc_count <= cc_count + 1;
  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Sampled a step after the edge so freshly updated flags are seen
  task automatic wait_status(input int bit_no, input logic val);
    repeat (2000)
      if (adapter_status[bit_no] !== val)
      begin
        @(posedge clk);
        #1;
      end
    check("status flag wait", {7'h0, val}, {7'h0, adapter_status[bit_no]});
  endtask : wait_status
  // Read strobe lasts one edge; data is taken just after it
  task automatic host_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    #1 d = host_rdata;
  endtask : host_read
  // Busy is polled first; a write on busy would stall the port
  task automatic host_write(input logic [7:0] b);
    wait_status(hcsp_pkg::BIT_CMD_BUSY, 1'b0);
    @(posedge clk);
    host_addr <= hcsp_pkg::ADDR_DATA;
    host_wdata <= b;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : host_write
  task automatic wait_cc(input int n);
    repeat (400)
      if (cc_count < n)
        @(posedge clk);
    check("completion count", 8'(n), 8'(cc_count));
  endtask : wait_cc
  // Test outcome settles through the synchroniser before the reset
  task automatic hard_reset(input logic fail);
    @(posedge clk);
    diag_error <= fail;
    repeat (3) @(posedge clk);
    hard_reset_request <= 1'b1;
    @(posedge clk);
    hard_reset_request <= 1'b0;
  endtask : hard_reset
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // Watchdog well past the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    {reset, clk_en, host_rd, host_wr, hard_reset_request} = 5'h18;
    {interrupt_valid, diag_error, mpu_busy} = 3'h0;
    {host_addr, host_wdata} = 10'h000;
    {err_count, n_compared, cc_count} = {32'h0, 32'h0, 32'h0};
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    host_read(hcsp_pkg::ADDR_STATUS, rd);
    check("status in self-test", 8'h80, rd);
    wait_status(hcsp_pkg::BIT_ADAPTER_READY, 1'b1);
    host_read(hcsp_pkg::ADDR_STATUS, rd);
    check("status after self-test", 8'h30, rd);
    host_write(hcsp_pkg::CMD_MAILBOX_INIT);
    for (int i = 0; i < 4; i++)
      host_write(8'h10 + 8'(i));
    wait_cc(1);
    host_read(hcsp_pkg::ADDR_STATUS, rd);
    check("status after init", 8'h10, rd);
    wait_status(hcsp_pkg::BIT_ADAPTER_READY, 1'b1);
    host_write(8'hff);
    wait_cc(2);
    host_read(hcsp_pkg::ADDR_STATUS, rd);
    check("status after bad opcode", 8'h11, rd);
    // Reply of ten bytes overfills the buffer while the host holds off
    @(posedge clk);
    interrupt_valid <= 1'b1;
    host_write(8'h04);
    repeat (400)
      if (mpu_reply_ready !== 1'b0)
        @(posedge clk);
    check("buffer refuses when full", 8'h00, {7'h0, mpu_reply_ready});
    for (int i = 0; i < 10; i++)
    begin
      wait_status(hcsp_pkg::BIT_DATA_IN_READY, 1'b1);
      host_read(hcsp_pkg::ADDR_DATA, rd);
      check("reply byte", 8'ha0 + 8'(i), rd);
      repeat (3) @(posedge clk);
    end
    #1 check("ready after last byte", 8'h00, {7'h0, adapter_status[2]});
    check("completion held", 8'h02, 8'(cc_count));
    @(posedge clk);
    interrupt_valid <= 1'b0;
    wait_cc(3);
    for (int i = 0; i < 2; i++)
    begin
      host_read(hcsp_pkg::ADDR_STATUS, rd);
      check("status after reply", 8'h10, rd);
    end
    // A busy local processor must take the ready flag down
    @(posedge clk);
    mpu_busy <= 1'b1;
    wait_status(hcsp_pkg::BIT_ADAPTER_READY, 1'b0);
    @(posedge clk);
    mpu_busy <= 1'b0;
    hard_reset(1'b1);
    wait_status(hcsp_pkg::BIT_DIAG_FAILURE, 1'b1);
    host_read(hcsp_pkg::ADDR_STATUS, rd);
    check("status after failed test", 8'h40, rd & 8'h7f);
    hard_reset(1'b0);
    wait_status(hcsp_pkg::BIT_ADAPTER_READY, 1'b1);
    host_read(hcsp_pkg::ADDR_STATUS, rd);
    check("status after retest", 8'h30, rd);
    complete_run();
  end
endmodule : hcsp_port_tb_top
bind hcsp_port hcsp_port_chk i_chk (.clk(clk), .reset(reset),
  .clk_en(clk_en), .host_addr(host_addr), .host_wr(host_wr),
  .hard_reset_request(hard_reset_request),
  .interrupt_valid(interrupt_valid), .mpu_cmd_valid(mpu_cmd_valid),
  .mpu_cmd_taken(mpu_cmd_taken), .command_complete(command_complete),
  .adapter_status(adapter_status));
